// ### src/sts_pin_sync.sv
/*
  Three-stage input synchroniser with agreement filter.
  Assumes inputs come from outside the clk domain; output follows a
  change once the second and third stages agree.
*/
`timescale 1ns/1ns
module sts_pin_sync #(
  parameter int W = 9
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Raw and cleaned levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] clean
);

  logic [W-1:0] stage1; // Only stage2 reads this
  logic [W-1:0] stage2;
  logic [W-1:0] stage3;

  // Shift chain
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stage1 <= '0;
      stage2 <= '0;
      stage3 <= '0;
    end else begin
      stage1 <= raw;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // Per-bit agreement filter rejects one-cycle glitches
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      clean <= '0;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (stage2[i] == stage3[i]) begin
          clean[i] <= stage3[i];
        end
      end
    end
  end

endmodule : sts_pin_sync

// ### src/sts_pkg.sv
/*
  Shared constants, types and helper functions of the sync and trigger
  sequencer: register map, field layout, reset values, source codes and
  trigger states.
  Assumes a 32-bit Avalon-MM slave port with byte addresses.
*/
package sts_pkg;

  // Register byte offsets
  localparam logic [7:0] ofs_sync_ctrl = 8'h00;
  localparam logic [7:0] ofs_trig_count = 8'h04;
  localparam logic [7:0] ofs_trig_delay = 8'h08;
  localparam logic [7:0] ofs_sample_period = 8'h0C;
  localparam logic [7:0] ofs_actual_delay = 8'h10;
  localparam logic [7:0] ofs_trig_source = 8'h14;
  localparam logic [7:0] ofs_control = 8'h18;
  localparam logic [7:0] ofs_status = 8'h1C;

  // Sync control field layout
  localparam int unsigned sel_w = 4;
  localparam int unsigned sync_role_bit = 0;
  localparam int unsigned sync_in_lsb = 4;
  localparam int unsigned sync_out_lsb = 8;

  // Control register bits
  localparam int unsigned ctl_arm_bit = 0;
  localparam int unsigned ctl_abort_bit = 1;

  // Status register layout
  localparam int unsigned stat_div_busy_bit = 8;
  localparam int unsigned stat_sync_bit = 9;

  // Line codes: 0..7 pick a bus line, 8 picks none
  localparam int unsigned bus_lines = 8;
  localparam logic [3:0] no_bus_line_code = 4'h8;

  // Roles
  typedef enum logic {
    sync_role_primary = 1'b0,
    sync_role_follower = 1'b1
  } sts_role_t;

  // Trigger source codes
  localparam int unsigned src_w = 5;
  localparam logic [4:0] src_immediate = 5'h00;
  localparam logic [4:0] src_pattern = 5'h01;
  localparam logic [4:0] src_pos_first = 5'h02;
  localparam logic [4:0] src_neg_first = 5'h0A;
  localparam logic [4:0] src_last = 5'h11;

  // Reset values
  localparam logic [30:0] trig_count_rst = 31'h0000_0001;
  localparam logic [31:0] trig_delay_rst = 32'h0000_0000;

  // One-hot trigger states
  typedef enum logic [4:0] {
    st_arm = 5'h01,
    st_trig = 5'h02,
    st_delay = 5'h04,
    st_acquire = 5'h08,
    st_next = 5'h10
  } sts_state_t;

  // Byte-enable merge of a write into a stored word
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0] be);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : be_merge

  // Legal line code: a bus line or none
  function automatic logic line_code_ok(input logic [3:0] code);
    return code <= no_bus_line_code;
  endfunction : line_code_ok

  // Bus line watched by an edge source
  function automatic logic [2:0] src_line(input logic [4:0] src);
    logic [4:0] idx;
    idx = (src >= src_neg_first) ? src - src_neg_first : src - src_pos_first;
    return idx[2:0];
  endfunction : src_line

endpackage : sts_pkg

// ### src/sts_round_div.sv
/*
  Sequential restoring divider, one quotient bit per clock.
  Assumes start is a one-cycle pulse and denom is nonzero; operands are
  captured at start, so they may change while busy.
*/
`timescale 1ns/1ns
module sts_round_div #(
  parameter int NUM_W = 33,
  parameter int DEN_W = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Operation
  input wire logic start,
  input wire logic [NUM_W-1:0] numer,
  input wire logic [DEN_W-1:0] denom,
  // Result
  output logic busy,
  output logic [NUM_W-1:0] quot
);

  localparam int CNT_W = $clog2(NUM_W + 1);

  logic [DEN_W:0] rem; // Partial remainder
  logic [DEN_W-1:0] den; // Captured divisor
  logic [CNT_W-1:0] steps; // Bits still to produce
  logic [DEN_W:0] trial;

  assign trial = {rem[DEN_W-1:0], quot[NUM_W-1]};
  assign busy = steps != '0;

  // Shift-subtract loop
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rem <= '0;
      den <= '0;
      quot <= '0;
      steps <= '0;
    end else if (start) begin
      rem <= '0;
      den <= denom;
      quot <= numer;
      steps <= CNT_W'(NUM_W);
    end else if (busy) begin
      steps <= steps - 1'b1;
      if (trial >= {1'b0, den}) begin
        rem <= trial - {1'b0, den};
        quot <= {quot[NUM_W-2:0], 1'b1};
      end else begin
        rem <= trial;
        quot <= {quot[NUM_W-2:0], 1'b0};
      end
    end
  end

endmodule : sts_round_div

// ### src/sts_top.sv
/*
  Sync routing and trigger sequencing with an Avalon-MM register slave.
  Assumes a single clock, a one-cycle sample_tick per sample period, and
  acquisition logic that answers acquire_start with acq_done.
*/
// Summary of operation
// - Role is sync primary or follower
// - Input select in both roles; none uses internal
// - Output select only as primary; none internal
// - Codes 0-7 pick lines, 8 none
// - Reset: primary role, both selects none
// - Primary may use equal or different lines
// - Wait triggers programmed times, then rearm
// - Count zero loops forever
// - Programmed delay after trigger before acquiring
// - Delay rounded to nearest whole sample period
// - Immediate source skips the trigger layer
`timescale 1ns/1ns
module sts_top #(
  parameter logic [31:0] PERIOD_RST = 32'h0000_03E8
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Trigger bus lines
  input wire logic [7:0] trig_bus_in,
  output logic [7:0] trig_bus_out,
  output logic [7:0] trig_bus_oe,
  // Internal sync line
  input wire logic sync_int_in,
  output logic sync_int_out,
  output logic sync_int_oe,
  // Sync source and recovered sync
  input wire logic sync_gen,
  output logic sync_recovered,
  // Sampling and acquisition
  input wire logic sample_tick,
  input wire logic pattern_trigger,
  input wire logic acq_done,
  output logic acquire_start,
  output logic acquiring,
  output logic armed
);

  // Configuration registers
  sts_pkg::sts_role_t sync_role_select;
  logic [3:0] sync_input_line_select;
  logic [3:0] sync_output_line_select;
  logic [30:0] trigger_wait_total; // Zero means endless
  logic [31:0] trig_delay; // Microseconds
  logic [31:0] sample_period; // Microseconds
  logic [31:0] actual_delay; // Whole sample periods
  logic [4:0] trig_source;

  // Bus handshake
  logic bus_ack; // Last cycle of an access
  logic bus_req;
  logic bus_stall;
  logic wr_take; // Write takes effect this edge
  logic [31:0] wr_sync;
  logic [31:0] wr_word;

  // Rounding divider
  logic div_start;
  logic div_busy;
  logic div_pending; // Divider result not yet stored
  logic [32:0] div_numer;
  logic [32:0] div_quot;

  // Synchronised lines
  logic [8:0] line_clean;
  logic [8:0] line_prev;
  logic [7:0] bus_clean;

  // Sequencer
  sts_pkg::sts_state_t state;
  sts_pkg::sts_state_t next_state;
  logic [30:0] trig_left;
  logic [31:0] delay_left;
  logic arm_req;
  logic abort_req;
  logic trig_hit;
  logic [2:0] watch_line;

  // Access handshake; answers at the second edge of a request unless a rounding stall holds it off
  assign bus_req = avs_read | avs_write;
  assign bus_stall = (div_pending || div_start) &&
    (avs_address == sts_pkg::ofs_trig_delay ||
     avs_address == sts_pkg::ofs_sample_period ||
     avs_address == sts_pkg::ofs_actual_delay);
  assign avs_waitrequest = bus_req & ~bus_ack;
  assign wr_take = avs_write & bus_ack;
  assign wr_word = avs_writedata;

  // Ack flop; holding it off keeps rounding reads coherent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_ack <= 1'b0;
    end else begin
      bus_ack <= bus_req & ~bus_ack & ~bus_stall;
    end
  end

  // Merged sync control word
  assign wr_sync = sts_pkg::be_merge({20'h0_0000, sync_output_line_select,
    sync_input_line_select, 3'h0, sync_role_select}, wr_word,
    avs_byteenable);

  // Sync configuration; illegal line codes reject the write
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_role_select <= sts_pkg::sync_role_primary;
      sync_input_line_select <= sts_pkg::no_bus_line_code;
      sync_output_line_select <= sts_pkg::no_bus_line_code;
    end else if (wr_take && avs_address == sts_pkg::ofs_sync_ctrl) begin
      if (sts_pkg::line_code_ok(wr_sync[sts_pkg::sync_in_lsb +:
            sts_pkg::sel_w]) &&
          sts_pkg::line_code_ok(wr_sync[sts_pkg::sync_out_lsb +:
            sts_pkg::sel_w])) begin
        sync_role_select <=
          sts_pkg::sts_role_t'(wr_sync[sts_pkg::sync_role_bit]);
        sync_input_line_select <=
          wr_sync[sts_pkg::sync_in_lsb +: sts_pkg::sel_w];
        sync_output_line_select <=
          wr_sync[sts_pkg::sync_out_lsb +: sts_pkg::sel_w];
      end
    end
  end

  // Trigger count, delay, period and source
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trigger_wait_total <= sts_pkg::trig_count_rst;
      trig_delay <= sts_pkg::trig_delay_rst;
      sample_period <= PERIOD_RST;
      trig_source <= sts_pkg::src_immediate;
    end else if (wr_take) begin
      unique case (avs_address)
        sts_pkg::ofs_trig_count: begin
          trigger_wait_total <= 31'(sts_pkg::be_merge(
            {1'b0, trigger_wait_total}, wr_word, avs_byteenable));
        end
        sts_pkg::ofs_trig_delay: begin
          trig_delay <= sts_pkg::be_merge(trig_delay, wr_word,
            avs_byteenable);
        end
        sts_pkg::ofs_sample_period: begin
          // A zero period cannot be divided by, so it is refused
          if (sts_pkg::be_merge(sample_period, wr_word, avs_byteenable)
              != 32'h0000_0000) begin
            sample_period <= sts_pkg::be_merge(sample_period, wr_word,
              avs_byteenable);
          end
        end
        sts_pkg::ofs_trig_source: begin
          if (avs_byteenable[0] &&
              wr_word[sts_pkg::src_w-1:0] <= sts_pkg::src_last) begin
            trig_source <= wr_word[sts_pkg::src_w-1:0];
          end
        end
        default: begin
          // Other offsets store nothing here
        end
      endcase
    end
  end

  // Arm and abort strobes from the control register
  assign arm_req = wr_take && avs_address == sts_pkg::ofs_control &&
    avs_byteenable[0] && wr_word[sts_pkg::ctl_arm_bit];
  assign abort_req = wr_take && avs_address == sts_pkg::ofs_control &&
    avs_byteenable[0] && wr_word[sts_pkg::ctl_abort_bit];

  // Read data, captured on every cycle of a read before its ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !bus_ack) begin
      unique case (avs_address)
        sts_pkg::ofs_sync_ctrl: avs_readdata <= {20'h0_0000,
          sync_output_line_select, sync_input_line_select, 3'h0,
          sync_role_select};
        sts_pkg::ofs_trig_count: avs_readdata <= {1'b0, trigger_wait_total};
        sts_pkg::ofs_trig_delay: avs_readdata <= trig_delay;
        sts_pkg::ofs_sample_period: avs_readdata <= sample_period;
        sts_pkg::ofs_actual_delay: avs_readdata <= actual_delay;
        sts_pkg::ofs_trig_source: avs_readdata <= {27'h000_0000,
          trig_source};
        sts_pkg::ofs_status: avs_readdata <= {22'h00_0000, sync_recovered,
          div_busy, 3'h0, state};
        default: avs_readdata <= 32'h0000_0000; // Unmapped reads zero
      endcase
    end
  end

  // Rounding: (delay + period/2) / period gives the nearest multiple
  assign div_numer = {1'b0, trig_delay} + {2'b00, sample_period[31:1]};

  // Start one cycle after an update, so the new value is used
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_start <= 1'b0;
    end else begin
      div_start <= wr_take && (avs_address == sts_pkg::ofs_trig_delay ||
        avs_address == sts_pkg::ofs_sample_period);
    end
  end

  sts_round_div #(
    .NUM_W(33),
    .DEN_W(32)
  ) u_round (
    .clk(clk),
    .rst_b(rst_b),
    .start(div_start),
    .numer(div_numer),
    .denom(sample_period),
    .busy(div_busy),
    .quot(div_quot)
  );

  // Store the rounded delay once the divider finishes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_pending <= 1'b0;
      actual_delay <= 32'h0000_0000; // Zero delay rounds to zero
    end else if (div_start) begin
      div_pending <= 1'b1;
    end else if (div_pending && !div_busy) begin
      div_pending <= 1'b0;
      actual_delay <= div_quot[31:0];
    end
  end

  // Bus lines and internal line pass the synchroniser
  sts_pin_sync #(
    .W(9)
  ) u_sync (
    .clk(clk),
    .rst_b(rst_b),
    .raw({sync_int_in, trig_bus_in}),
    .clean(line_clean)
  );
  assign bus_clean = line_clean[7:0];

  // Sync input selection applies in either role
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_recovered <= 1'b0;
    end else if (sync_input_line_select == sts_pkg::no_bus_line_code) begin
      sync_recovered <= line_clean[sts_pkg::bus_lines];
    end else begin
      sync_recovered <= bus_clean[sync_input_line_select[2:0]];
    end
  end

  // Sync drive; input and output selects are independent
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_int_out <= 1'b0;
      sync_int_oe <= 1'b0;
      trig_bus_out <= 8'h00;
      trig_bus_oe <= 8'h00;
    end else if (sync_role_select == sts_pkg::sync_role_primary) begin
      sync_int_out <= sync_gen;
      sync_int_oe <= 1'b1;
      trig_bus_out <= {8{sync_gen}};
      // Lines 0..7 drive one bus line; none keeps the bus quiet
      trig_bus_oe <= (sync_output_line_select == sts_pkg::no_bus_line_code)
        ? 8'h00 : 8'h01 << sync_output_line_select[2:0];
    end else begin
      // A follower drives nothing, whatever the output select holds
      sync_int_out <= 1'b0;
      sync_int_oe <= 1'b0;
      trig_bus_out <= 8'h00;
      trig_bus_oe <= 8'h00;
    end
  end

  // Edge history of cleaned lines
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      line_prev <= 9'h000;
    end else begin
      line_prev <= line_clean;
    end
  end

  // Trigger event from the selected source
  assign watch_line = sts_pkg::src_line(trig_source);
  always_comb begin
    trig_hit = 1'b0;
    if (trig_source == sts_pkg::src_pattern) begin
      trig_hit = pattern_trigger;
    end else if (trig_source >= sts_pkg::src_neg_first) begin
      trig_hit = line_prev[watch_line] & ~bus_clean[watch_line];
    end else if (trig_source >= sts_pkg::src_pos_first) begin
      trig_hit = ~line_prev[watch_line] & bus_clean[watch_line];
    end
  end

  // Next trigger state
  always_comb begin
    next_state = state;
    unique case (state)
      sts_pkg::st_arm: begin
        if (arm_req) begin
          next_state = (trig_source == sts_pkg::src_immediate)
            ? sts_pkg::st_acquire : sts_pkg::st_trig;
        end
      end
      sts_pkg::st_trig: begin
        if (trig_hit) begin
          next_state = sts_pkg::st_delay;
        end
      end
      sts_pkg::st_delay: begin
        if (delay_left == 32'h0000_0000) begin
          next_state = sts_pkg::st_acquire;
        end
      end
      sts_pkg::st_acquire: begin
        if (acq_done) begin
          next_state = sts_pkg::st_next;
        end
      end
      sts_pkg::st_next: begin
        if (trigger_wait_total != 31'h0000_0000 &&
            trig_left == 31'h0000_0001) begin
          next_state = sts_pkg::st_arm;
        end else if (trig_source == sts_pkg::src_immediate) begin
          next_state = sts_pkg::st_acquire;
        end else begin
          next_state = sts_pkg::st_trig;
        end
      end
      default: next_state = sts_pkg::st_arm; // Illegal code recovers
    endcase
  end

  // State register; abort returns to the arm layer
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sts_pkg::st_arm;
    end else if (abort_req) begin
      state <= sts_pkg::st_arm;
    end else begin
      state <= next_state;
    end
  end

  // Trigger passes left in this arm cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_left <= 31'h0000_0000;
    end else if (state == sts_pkg::st_arm && arm_req) begin
      trig_left <= trigger_wait_total;
    end else if (state == sts_pkg::st_next &&
                 trigger_wait_total != 31'h0000_0000) begin
      trig_left <= trig_left - 31'h0000_0001;
    end
  end

  // Delay down-counter, loaded on the trigger event
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      delay_left <= 32'h0000_0000;
    end else if (state == sts_pkg::st_trig && trig_hit) begin
      delay_left <= actual_delay;
    end else if (state == sts_pkg::st_delay && sample_tick &&
                 delay_left != 32'h0000_0000) begin
      delay_left <= delay_left - 32'h0000_0001;
    end
  end

  // Acquisition outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acquire_start <= 1'b0;
      acquiring <= 1'b0;
      armed <= 1'b0;
    end else begin
      acquire_start <= (next_state == sts_pkg::st_acquire) &&
        (state != sts_pkg::st_acquire) && !abort_req;
      acquiring <= (next_state == sts_pkg::st_acquire) && !abort_req;
      armed <= (next_state != sts_pkg::st_arm) && !abort_req;
    end
  end

endmodule : sts_top

// ### tb/sts_bus_peer.sv
/* Far instruments on the trigger bus and the internal sync line.
   Assumes the bench sets the far drive levels and the hub loop. */
`timescale 1ns/1ns
module sts_bus_peer (
  // Lines as driven by the block
  input wire logic [7:0] bus_out,
  input wire logic [7:0] bus_oe,
  input wire logic int_out,
  input wire logic int_oe,
  // Far drive, and hub loop from line 3 to line 5
  input wire logic [7:0] lvl,
  input wire logic hub,
  // Resolved levels
  output logic [7:0] bus_in,
  output logic int_in
);
  logic [7:0] wire_lvl; // Line level after both parties
  assign wire_lvl = (bus_out & bus_oe) | (lvl & ~bus_oe);
  // Star hub returns line 3 on line 5
  always_comb begin
    bus_in = wire_lvl;
    if (hub) bus_in[5] = wire_lvl[3];
  end
  // Far primary feeds the internal line when we stay off it
  assign int_in = int_oe ? int_out : lvl[5];
endmodule : sts_bus_peer

// ### tb/sts_properties.sv
/* Port checker for the sync and trigger sequencer.
   Assumes a bind from the bench; one clock, rst_b active low. */
`timescale 1ns/1ns
module sts_properties (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Register bus
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  // Sync pins
  input wire logic sync_gen,
  input wire logic sync_int_out,
  input wire logic sync_int_oe,
  input wire logic [7:0] trig_bus_out,
  input wire logic [7:0] trig_bus_oe,
  // Sequencer
  input wire logic acq_done,
  input wire logic acquire_start,
  input wire logic acquiring,
  input wire logic armed
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // Steps: a pending access, and the end of one acquisition
  sequence req_s;
    avs_read || avs_write;
  endsequence
  sequence acq_end_s;
    acquiring && acq_done;
  endsequence
  // Rounding stall is bounded, so no access hangs
  wait_bound_a: assert property (
    req_s |-> ##[0:40] !avs_waitrequest) else $error("access hung");
  role_drive_a: assert property (
    sync_int_oe |-> sync_int_out == $past(sync_gen))
    else $error("primary sync not sent");
  bus_copy_a: assert property (
    sync_int_oe |-> trig_bus_out == {8{$past(sync_gen)}})
    else $error("bus lines miss sync");
  follower_quiet_a: assert property (
    !sync_int_oe |-> trig_bus_oe == 8'h00 && !sync_int_out)
    else $error("follower drives a line");
  one_line_a: assert property ($onehot0(trig_bus_oe))
    else $error("several lines driven");
  start_pulse_a: assert property (
    acquire_start |=> !acquire_start) else $error("long start");
  start_armed_a: assert property (
    acquire_start |-> armed) else $error("start while disarmed");
  acq_end_a: assert property (
    acq_end_s |=> !acquiring) else $error("acquiring after done");
  idle_none_a: assert property (
    !armed |-> !acquiring) else $error("acquiring in arm layer");
endmodule : sts_properties

// ### tb/sts_top_test.sv
/* Self-checking bench for the sync and trigger sequencer.
   Assumes sts_top with its package, and sts_bus_peer as far side. */
`timescale 1ns/1ns
module sts_top_test;
  logic clk, rst_b, rd, wr, sg, tick, pat, done, hub;
  logic si, so, soe, srec, wq, ast, acq, arm;
  logic [7:0] adr, lvl, bin, bo, boe;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  int seed = 32'hb522;
  int errors, compares, cyc, n, c, p, d;
  int dt[3] = '{4, 5, 15}; // Near the half-period rounding points
  logic [31:0] expq[$]; // Expected read data
  sts_top sts_top_inst (.clk(clk), .rst_b(rst_b), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wq),
    .trig_bus_in(bin), .trig_bus_out(bo), .trig_bus_oe(boe),
    .sync_int_in(si), .sync_int_out(so), .sync_int_oe(soe),
    .sync_gen(sg), .sync_recovered(srec), .sample_tick(tick),
    .pattern_trigger(pat), .acq_done(done), .acquire_start(ast),
    .acquiring(acq), .armed(arm));
  sts_bus_peer peer (.bus_out(bo), .bus_oe(boe), .int_out(so),
    .int_oe(soe), .lvl(lvl), .hub(hub), .bus_in(bin), .int_in(si));
  initial begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task end_sim;
    if (errors == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_sim
  task chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      errors++;
      $display("[ERR] %0t got %h want %h", $time, s, e);
    end
  endtask : chk
  // One access, held until waitrequest low; outputs settle after
  task bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= v;
    @(posedge clk);
    while (wq) @(posedge clk);
    rd <= 0;
    wr <= 0;
    repeat (3) @(posedge clk);
  endtask : bus
  task rdc(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    bus(0, a, 0);
  endtask : rdc
  // Read data checked at the completing edge
  always @(posedge clk) if (rd && !wq) chk(rdat, expq.pop_front());
  // Cycle count, tick every 16 cycles, slow random sync, timeout
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tick <= cyc[3:0] == 0;
    if (cyc[4:0] == 0) sg <= 1'($random(seed));
    if (cyc == 30000) begin
      errors++;
      end_sim;
    end
  end
  task calm; // Into the steady part of a sync period
    do @(posedge clk); while (cyc[4:0] != 24);
  endtask : calm
  task wast; // Ticks until acquisition starts
    n = 0;
    c = 0;
    while (!ast && c < 300) begin
      @(posedge clk);
      c++;
      if (tick && !ast) n++;
    end
  endtask : wast
  task fin;
    done <= 1;
    @(posedge clk);
    done <= 0;
    repeat (3) @(posedge clk);
  endtask : fin
  initial begin
    {rst_b, rd, wr, sg, tick, pat, done, hub, adr, wd, lvl} = '0;
    be = 4'hf;
    repeat (16) @(posedge clk);
    rst_b <= 1;
    repeat (2) @(posedge clk);
    chk(soe, 1);
    rdc(8'h00, 32'h0000_0880);
    rdc(8'h04, 32'h0000_0001);
    rdc(8'h08, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    // Every bus line code as primary output
    for (int i = 0; i < 8; i++) begin
      bus(1, 8'h00, 32'h0000_0080 | 32'(i << 8));
      chk(boe, 8'h01 << i);
    end
    hub <= 1;
    bus(1, 8'h00, 32'h0000_0350);
    repeat (2) begin
      calm;
      chk(srec, sg);
      chk(bo[3], sg);
    end
    hub <= 0;
    bus(1, 8'h00, 32'h0000_0880);
    calm;
    chk(srec, sg);
    chk(boe, 0);
    bus(1, 8'h00, 32'h0000_0851);
    chk(soe, 0);
    repeat (3) begin
      lvl <= 8'($random(seed));
      repeat (12) @(posedge clk);
      chk(srec, lvl[5]);
    end
    bus(1, 8'h00, 32'h0000_0890);
    rdc(8'h00, 32'h0000_0851);
    bus(1, 8'h00, 32'h0000_0880);
    lvl <= 0;
    for (int k = 0; k < 6; k++) begin
      p = (k < 3) ? 1 + ($random(seed) & 15) : 10;
      d = (k < 3) ? $random(seed) & 255 : dt[k - 3];
      bus(1, 8'h0C, p);
      bus(1, 8'h08, d);
      rdc(8'h10, 32'((2 * d + p) / (2 * p)));
    end
    bus(1, 8'h08, 32'h0000_0019);
    rdc(8'h10, 32'h0000_0003);
    bus(1, 8'h14, 32'h0000_0002);
    bus(1, 8'h04, 32'h0000_0002);
    bus(1, 8'h18, 32'h0000_0001);
    chk(arm, 1);
    repeat (2) begin
      do @(posedge clk); while (!tick);
      lvl[0] <= 1;
      wast;
      chk(n, 3);
      lvl[0] <= 0;
      fin;
    end
    chk(arm, 0);
    bus(1, 8'h08, 32'h0000_0000);
    rdc(8'h10, 32'h0000_0000);
    bus(1, 8'h14, 32'h0000_0001);
    bus(1, 8'h04, 32'h0000_0000);
    bus(1, 8'h18, 32'h0000_0001);
    repeat (3) begin
      pat <= 1;
      wast;
      chk(ast, 1);
      pat <= 0;
      fin;
      chk(arm, 1);
    end
    bus(1, 8'h18, 32'h0000_0002);
    chk(arm, 0);
    bus(1, 8'h14, 32'h0000_0000);
    bus(1, 8'h04, 32'h0000_0001);
    bus(1, 8'h18, 32'h0000_0001);
    chk(acq, 1);
    fin;
    chk(arm, 0);
    end_sim;
  end
endmodule : sts_top_test
bind sts_top sts_properties sts_properties_inst (.clk(clk), .rst_b(rst_b),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_waitrequest(avs_waitrequest), .sync_gen(sync_gen),
  .sync_int_out(sync_int_out), .sync_int_oe(sync_int_oe),
  .trig_bus_out(trig_bus_out), .trig_bus_oe(trig_bus_oe),
  .acq_done(acq_done), .acquire_start(acquire_start),
  .acquiring(acquiring), .armed(armed));
